//--- verilog/compare_unit_map.svh
// Register offsets, field positions, mode codes and reset values of the compare unit
`ifndef COMPARE_UNIT_MAP_SVH
`define COMPARE_UNIT_MAP_SVH
`define OFS_UNIT_CONTROL 12'h000
`define OFS_COMPARE_LOW 12'h004
`define OFS_COMPARE_HIGH 12'h008
`define OFS_STATUS 12'h00c
`define OFS_MASK 12'h010
`define OFS_TIMER_LOW 12'h014
`define OFS_TIMER_HIGH 12'h018
`define OFS_SETUP 12'h01c
`define MODE_SET 4'h8
`define MODE_CLEAR 4'h9
`define MODE_SOFT_IRQ 4'ha
`define MODE_SPECIAL 4'hb
`define MODE_TOGGLE 4'h2
`define ST_MATCH 0
`define ST_OVF 1
`define ST_SPECIAL 2
`define SETUP_TIMER_ON 0
`define SETUP_ADC_ON 1
`define SETUP_ALT_PIN 2
`define SETUP_ENHANCED 3
`define SETUP_ADC_UNIT 4
`define CTRL_RESET 8'h00
`define STATUS_BITS 3
`endif

//--- verilog/compare_unit_pkg.sv
// Types shared by the compare unit
package compare_unit_pkg;
	typedef struct packed {
		logic [1:0] output_config_field;
		logic [1:0] duty_low_bits;
		logic [3:0] match_mode_field;
	} unit_control_s;
	typedef enum logic [1:0] {
		TRIG_IDLE,
		TRIG_ARMED
	} trig_state_e;
endpackage : compare_unit_pkg

//--- verilog/timer_compare_unit.sv
// Compare unit with its 16-bit timer, APB registers and interrupt logic
`timescale 1ns/1ns
`include "compare_unit_map.svh"
module timer_compare_unit import compare_unit_pkg::*; (
	input wire logic ref_clk_i, // System clock, 20 MHz
	input wire logic reset_i, // Synchronous, active high
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic compare_pin_o, // Primary pin output
	output logic compare_pin_oe_o, // Primary pin driven by unit
	output logic compare_pin_alt_o, // Alternate pin output
	output logic compare_pin_alt_oe_o, // Alternate pin driven by unit
	output logic special_trigger_o, // Special event trigger pulse
	output logic adc_go_o, // Sets converter go bit
	output logic irq_o // Level interrupt
);
	// ==========================================================
	// State
	// ==========================================================
	unit_control_s ctrl_q; // Control register
	logic [15:0] compare_q; // Compare value
	logic [15:0] timer_q; // Free-running timer count
	logic [`STATUS_BITS-1:0] status_q; // Sticky events
	logic [`STATUS_BITS-1:0] mask_q; // Interrupt enables
	logic [4:0] setup_q; // Timer on, ADC on, alt pin, enhanced, ADC unit
	logic latch_q; // Compare output latch
	logic match_q; // Match seen last cycle, for edge
	trig_state_e trig_q; // Pending timer reset
	logic [31:0] rdata_d;
	logic wr_en;
	logic rd_en;
	logic match; // Combinational equality
	logic match_rise; // First cycle of a match
	logic [3:0] mode;
	logic pin_mode;
	logic timer_clear; // Trigger reset of timer
	logic timer_hold; // Count paused on the trigger tick
	logic [`STATUS_BITS-1:0] ev;

	// Decodes whether a mode drives the pin
	function automatic logic drives_pin(input logic [3:0] m);
		drives_pin = (m == `MODE_SET) || (m == `MODE_CLEAR) || (m == `MODE_TOGGLE);
	endfunction : drives_pin

	// Selects one byte of a write
	function automatic logic [7:0] wbyte(input logic [31:0] d);
		wbyte = d[7:0];
	endfunction : wbyte

	assign mode = ctrl_q.match_mode_field;
	assign pin_mode = drives_pin(mode);
	// Runs on the system clock only; a stopped clock freezes the compare
	assign match = (compare_q == timer_q);
	// One action per match: only the first cycle of equality counts
	assign match_rise = match && !match_q && (mode != 4'h0);
	// Reset only if the match still holds at the next tick
	assign timer_clear = (trig_q == TRIG_ARMED) && match && (mode == `MODE_SPECIAL);
	// The count moves every clock, so a match would last one cycle only;
	// pausing it on the trigger tick keeps the match for the reset tick and
	// leaves a cycle in which a compare write can still cancel the reset
	assign timer_hold = match_rise && (mode == `MODE_SPECIAL);
	// Bus access phase; zero wait states
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && penable_i && !pwrite_i;

	// ==========================================================
	// Timer
	// ==========================================================
	// Counts each clock while enabled; trigger reset wins over count
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			timer_q <= 16'h0000;
		end else if (wr_en && paddr_i == `OFS_TIMER_LOW) begin
			timer_q[7:0] <= wbyte(pwdata_i);
		end else if (wr_en && paddr_i == `OFS_TIMER_HIGH) begin
			timer_q[15:8] <= wbyte(pwdata_i);
		end else if (timer_clear) begin
			timer_q <= 16'h0000;
		end else if (timer_hold) begin
			timer_q <= timer_q;
		end else if (setup_q[`SETUP_TIMER_ON]) begin
			timer_q <= timer_q + 16'h0001;
		end
	end

	// Edge memory for match detection
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	// ==========================================================
	// Special event trigger sequence
	// ==========================================================
	// Armed by the match edge, resolved on the following tick
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			trig_q <= TRIG_IDLE;
		end else begin
			case (trig_q)
				TRIG_IDLE: begin
					if (match_rise && mode == `MODE_SPECIAL) begin
						trig_q <= TRIG_ARMED;
					end
				end
				TRIG_ARMED: begin
					trig_q <= TRIG_IDLE;
				end
				default: begin
					trig_q <= TRIG_IDLE;
				end
			endcase
		end
	end

	// Trigger pulse and converter start register the match edge
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			special_trigger_o <= 1'b0;
			adc_go_o <= 1'b0;
		end else begin
			special_trigger_o <= match_rise && mode == `MODE_SPECIAL;
			adc_go_o <= match_rise && mode == `MODE_SPECIAL && setup_q[`SETUP_ADC_UNIT]
				&& setup_q[`SETUP_ADC_ON];
		end
	end

	// ==========================================================
	// Compare output latch
	// ==========================================================
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			latch_q <= 1'b0;
		end else if (wr_en && paddr_i == `OFS_UNIT_CONTROL && pwdata_i[7:0] == `CTRL_RESET) begin
			latch_q <= 1'b0;
		end else if (match_rise) begin
			case (mode)
				`MODE_SET: latch_q <= 1'b1;
				`MODE_CLEAR: latch_q <= 1'b0;
				`MODE_TOGGLE: latch_q <= !latch_q;
				default: latch_q <= latch_q;
			endcase
		end
	end

	// Pins follow the latch; routing picks primary or alternate
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			compare_pin_o <= 1'b0;
			compare_pin_oe_o <= 1'b0;
			compare_pin_alt_o <= 1'b0;
			compare_pin_alt_oe_o <= 1'b0;
		end else begin
			compare_pin_o <= latch_q;
			compare_pin_alt_o <= latch_q;
			compare_pin_oe_o <= pin_mode && !setup_q[`SETUP_ALT_PIN];
			compare_pin_alt_oe_o <= pin_mode && setup_q[`SETUP_ALT_PIN];
		end
	end

	// ==========================================================
	// Interrupt status
	// ==========================================================
	// Overflow only on natural wrap, never on trigger reset
	assign ev[`ST_MATCH] = match_rise;
	assign ev[`ST_OVF] = setup_q[`SETUP_TIMER_ON] && timer_q == 16'hffff && !timer_clear && !timer_hold
		&& !(wr_en && (paddr_i == `OFS_TIMER_LOW || paddr_i == `OFS_TIMER_HIGH));
	assign ev[`ST_SPECIAL] = match_rise && mode == `MODE_SPECIAL;

	// Write one to clear; a new event wins over the clear
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			status_q <= '0;
		end else if (wr_en && paddr_i == `OFS_STATUS) begin
			status_q <= (status_q & ~pwdata_i[`STATUS_BITS-1:0]) | ev;
		end else begin
			status_q <= status_q | ev;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_q & mask_q);
		end
	end

	// ==========================================================
	// Software registers
	// ==========================================================
	// Enhanced field only writable on enhanced instances
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q <= `CTRL_RESET;
			compare_q <= 16'h0000;
			mask_q <= '0;
			setup_q <= 5'h00;
		end else if (wr_en) begin
			case (paddr_i)
				`OFS_UNIT_CONTROL: begin
					ctrl_q <= wbyte(pwdata_i);
					if (!setup_q[`SETUP_ENHANCED]) begin
						ctrl_q.output_config_field <= 2'h0;
					end
				end
				`OFS_COMPARE_LOW: compare_q[7:0] <= wbyte(pwdata_i);
				`OFS_COMPARE_HIGH: compare_q[15:8] <= wbyte(pwdata_i);
				`OFS_MASK: mask_q <= pwdata_i[`STATUS_BITS-1:0];
				`OFS_SETUP: setup_q <= pwdata_i[4:0];
				default: ;
			endcase
		end
	end

	// Read mux; upper bits are zero
	always_comb begin
		rdata_d = 32'h00000000;
		case (paddr_i)
			`OFS_UNIT_CONTROL: rdata_d[7:0] = ctrl_q;
			`OFS_COMPARE_LOW: rdata_d[7:0] = compare_q[7:0];
			`OFS_COMPARE_HIGH: rdata_d[7:0] = compare_q[15:8];
			`OFS_STATUS: rdata_d[`STATUS_BITS-1:0] = status_q;
			`OFS_MASK: rdata_d[`STATUS_BITS-1:0] = mask_q;
			`OFS_TIMER_LOW: rdata_d[7:0] = timer_q[7:0];
			`OFS_TIMER_HIGH: rdata_d[7:0] = timer_q[15:8];
			`OFS_SETUP: rdata_d[4:0] = setup_q;
			default: rdata_d = 32'h00000000;
		endcase
	end

	// Answers in the setup cycle's following access cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rdata_d : 32'h00000000;
			pslverr_o <= psel_i && !penable_i && (paddr_i > `OFS_SETUP || paddr_i[1:0] != 2'b00);
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	// A standing trigger request clears the count unless software wrote it
	a_trig_resets_timer: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		timer_clear |=> timer_q == 16'h0000 || $past(wr_en))
		else $error("timer not cleared by trigger");
	// The count pauses one tick so the reset can follow the trigger
	a_hold_before_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(timer_hold && !wr_en) |=> $stable(timer_q))
		else $error("timer moved before trigger reset");
	// A match gone by the reset tick leaves the count running
	a_removed_match_holds: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(trig_q == TRIG_ARMED && !match) |-> !timer_clear)
		else $error("reset after match removed");
	// Flag rises together with the latch action
	a_match_flag_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		match_rise |=> status_q[`ST_MATCH])
		else $error("match flag missing");
	// Neither the pause nor the trigger reset counts as a wrap
	a_trig_no_ovf: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(timer_clear || timer_hold) |-> !ev[`ST_OVF])
		else $error("overflow flag on trigger");
	// Flag-only and trigger modes release the pins
	a_soft_no_pin: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(mode == `MODE_SOFT_IRQ || mode == `MODE_SPECIAL) |=> !compare_pin_oe_o && !compare_pin_alt_oe_o)
		else $error("pin driven in non-pin mode");
	// Clearing the control register drops the latch, then the pin
	a_ctrl_zero_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(wr_en && paddr_i == `OFS_UNIT_CONTROL && pwdata_i[7:0] == 8'h00) |=> !latch_q ##1 !compare_pin_o)
		else $error("latch not forced low");
	// Converter start only with a trigger on the converter unit
	a_adc_only_unit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		adc_go_o |-> special_trigger_o && $past(setup_q[`SETUP_ADC_UNIT]))
		else $error("converter started wrongly");
	// Plain units never start the converter
	a_no_go_elsewhere: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!setup_q[`SETUP_ADC_UNIT] |=> !adc_go_o)
		else $error("converter started by plain unit");
	// Set mode drives the latch high, then the pin
	a_set_drives_high: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(match_rise && mode == `MODE_SET) |=> latch_q ##1 compare_pin_o)
		else $error("set action missing");
	// Clear mode drives the latch low
	a_clear_drives_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(match_rise && mode == `MODE_CLEAR) |=> !latch_q)
		else $error("clear action missing");
	// Toggle mode inverts the latch; bus writes excluded
	a_toggle_flips: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(match_rise && mode == `MODE_TOGGLE && !wr_en) |=> latch_q != $past(latch_q))
		else $error("toggle action missing");
	// Trigger pulse and armed state follow the match
	a_trigger_on_match: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(match_rise && mode == `MODE_SPECIAL) |=> special_trigger_o ##0 trig_q == TRIG_ARMED)
		else $error("trigger missing");
	// Never both routes at once
	a_pin_route: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!(compare_pin_oe_o && compare_pin_alt_oe_o))
		else $error("both pins driven");
	// Plain units keep the output config field at zero
	a_config_plain_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(wr_en && paddr_i == `OFS_UNIT_CONTROL && !setup_q[`SETUP_ENHANCED]) |=> ctrl_q.output_config_field == 2'h0)
		else $error("config field set on plain unit");

	// ==========================================================
	// Cover points
	// ==========================================================
	// Main scenarios: pin action, trigger reset, cancel, wrap, converter start
	c_toggle: cover property (@(posedge ref_clk_i) match_rise && mode == `MODE_TOGGLE);
	c_special: cover property (@(posedge ref_clk_i) timer_clear);
	c_cancel: cover property (@(posedge ref_clk_i) trig_q == TRIG_ARMED && !match);
	c_overflow: cover property (@(posedge ref_clk_i) ev[`ST_OVF]);
	c_adc_start: cover property (@(posedge ref_clk_i) adc_go_o);
endmodule : timer_compare_unit

//--- tb/pin_load_model.sv
// Load on the compare pins: pull-down unless the pin is driven as an output
`timescale 1ns/1ns
module pin_load_model (
	input wire logic pin_i, // Level offered by the unit
	input wire logic oe_i, // Unit drives the pin
	input wire logic dir_out_i, // Pin direction bit cleared by software
	output logic level_o // Level seen by the load
);
	// ==========================================
	// Wire level
	// Pull-down, so a released pin never shows a stale one
	assign level_o = (oe_i && dir_out_i) ? pin_i : 1'b0;
endmodule : pin_load_model

//--- tb/timer_compare_unit_tb.sv
// Register-level testbench of the compare unit
`timescale 1ns/1ns
`include "compare_unit_map.svh"
module timer_compare_unit_tb;
	// ==========================================
	// Signals
	logic clk, rst, psel, pen, pwr;
	logic [11:0] pa;
	logic [31:0] pwd, prd, q;
	logic prdy, perr, last_err, pin, oe, apin, aoe, trig, go, irq;
	logic lvl, alvl;
	logic dir_out = 1'b1; // Software keeps pins as outputs
	int err_count = 0, cmp_count = 0, trig_n = 0, go_n = 0;
	logic [3:0] modes [4] = '{4'h8, 4'h9, 4'h2, 4'h8}; // Set, clear, toggle, set
	logic lvls [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	timer_compare_unit u_timer_compare_unit (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(prdy), .pslverr_o(perr), .compare_pin_o(pin), .compare_pin_oe_o(oe),
		.compare_pin_alt_o(apin), .compare_pin_alt_oe_o(aoe), .special_trigger_o(trig),
		.adc_go_o(go), .irq_o(irq));
	pin_load_model u_pin_load_model (.pin_i(pin), .oe_i(oe), .dir_out_i(dir_out), .level_o(lvl));
	pin_load_model u_pin_load_model_alt (.pin_i(apin), .oe_i(aoe), .dir_out_i(dir_out), .level_o(alvl));
	// ==========================================
	// Clock and pulse counters
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (trig === 1'b1) trig_n++;
		if (go === 1'b1) go_n++;
	end
	// ==========================================
	// Tasks
	task print_verdict;
		$display("Compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// One APB transfer, held until pready, then one idle edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pwr <= w; pa <= a; pwd <= d; pen <= 1'b0;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			print_verdict();
		end
		q = prd;
		last_err = perr;
		psel <= 1'b0; pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Read until a status bit shows, bounded
	task poll(input logic [31:0] m);
		int n;
		for (n = 0; n < 100; n++) begin
			apb(1'b0, `OFS_STATUS, 0);
			if ((q & m) != 0) break;
		end
		if (n >= 100) begin
			err_count++;
			print_verdict();
		end
	endtask : poll
	// Stop timer, zero it, load compare, mode, clear flags, start
	task run(input logic [3:0] m, input logic [7:0] c, input logic [31:0] s);
		apb(1'b1, `OFS_SETUP, 0);
		apb(1'b1, `OFS_TIMER_LOW, 0);
		apb(1'b1, `OFS_TIMER_HIGH, 0);
		apb(1'b1, `OFS_COMPARE_LOW, c);
		apb(1'b1, `OFS_COMPARE_HIGH, 0);
		apb(1'b1, `OFS_UNIT_CONTROL, m);
		apb(1'b1, `OFS_STATUS, 32'h7);
		apb(1'b1, `OFS_SETUP, s);
	endtask : run
	// ==========================================
	// Main sequence
	initial begin
		rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; pa = '0; pwd = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `OFS_UNIT_CONTROL, 0);
		chk(q, 32'h0);
		apb(1'b0, 12'h020, 0);
		chk({31'h0, last_err}, 32'h1);
		chk(q, 32'h0);
		apb(1'b1, `OFS_UNIT_CONTROL, 32'hffff);
		apb(1'b0, `OFS_UNIT_CONTROL, 0);
		chk(q, 32'h3f);
		apb(1'b1, `OFS_SETUP, 32'h8);
		apb(1'b1, `OFS_UNIT_CONTROL, 32'hff);
		apb(1'b0, `OFS_UNIT_CONTROL, 0);
		chk(q, 32'hff);
		apb(1'b1, `OFS_COMPARE_HIGH, 32'h1a5);
		apb(1'b0, `OFS_COMPARE_HIGH, 0);
		chk(q, 32'ha5);
		apb(1'b1, `OFS_UNIT_CONTROL, 0);
		// Pin actions on both pin routes
		for (int i = 0; i < 4; i++) begin
			run(modes[i], 8'h10, (i == 3) ? 32'h5 : 32'h1);
			poll(32'h1);
			repeat (3) @(posedge clk);
			chk((i == 3) ? alvl : lvl, lvls[i]);
			chk((i == 3) ? oe : aoe, 1'b0);
		end
		apb(1'b1, `OFS_UNIT_CONTROL, 0);
		repeat (3) @(posedge clk);
		chk(apin, 1'b0);
		// Flag only: interrupt raised, masked, cleared
		apb(1'b1, `OFS_MASK, 32'h1);
		run(4'ha, 8'h10, 32'h1);
		poll(32'h1);
		chk(oe, 1'b0);
		chk(irq, 1'b1);
		apb(1'b1, `OFS_MASK, 0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(1'b1, `OFS_MASK, 32'h1);
		apb(1'b1, `OFS_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		// Special event trigger with and without the converter
		for (int k = 0; k < 2; k++) begin
			run(4'hb, 8'h20, k ? 32'h11 : 32'h13);
			trig_n = 0;
			go_n = 0;
			poll(32'h4);
			poll(32'h4);
			chk(oe, 1'b0);
			apb(1'b0, `OFS_TIMER_LOW, 0);
			chk(q <= 32'h20, 1'b1);
			apb(1'b0, `OFS_STATUS, 0);
			chk(q & 32'h2, 32'h0);
			chk(trig_n > 0, 1'b1);
			chk(go_n, k ? 0 : trig_n);
		end
		// Trigger at the top of the count: its reset must not look like a wrap
		apb(1'b1, `OFS_SETUP, 0);
		apb(1'b1, `OFS_TIMER_LOW, 32'hf0);
		apb(1'b1, `OFS_TIMER_HIGH, 32'hff);
		apb(1'b1, `OFS_COMPARE_LOW, 32'hff);
		apb(1'b1, `OFS_COMPARE_HIGH, 32'hff);
		apb(1'b1, `OFS_STATUS, 32'h7);
		apb(1'b1, `OFS_SETUP, 32'h1);
		poll(32'h4);
		apb(1'b0, `OFS_STATUS, 0);
		chk(q & 32'h2, 32'h0);
		print_verdict();
	end
endmodule : timer_compare_unit_tb
